//--- hw/hscr_map.svh
// Register offsets, field positions and reset values for the hub config bank.
`ifndef HSCR_MAP_SVH
`define HSCR_MAP_SVH
// ==========================================
// Register offsets
`define HSCR_REG_STCMD 8'h00
`define HSCR_REG_VIDL 8'h01
`define HSCR_REG_RIDH 8'h06
`define HSCR_REG_HUB_CONFIG_FIRST_REG 8'h07
`define HSCR_REG_PROT_LO 8'h01
`define HSCR_REG_PROT_HI 8'h10
// ==========================================
// Status/command bit positions
`define HSCR_STC_RESET 2
`define HSCR_STC_LOCK 1
`define HSCR_STC_ATTACH 0
// ==========================================
// Configuration byte 1 bit positions
`define HSCR_HUB_CONFIG_FIRST_REG_PWR 7
`define HSCR_HUB_CONFIG_FIRST_REG_LED 6
`define HSCR_HUB_CONFIG_FIRST_REG_FS 5
`define HSCR_HUB_CONFIG_FIRST_REG_TT 4
`define HSCR_HUB_CONFIG_FIRST_REG_EOP 3
`define HSCR_HUB_CONFIG_FIRST_REG_OC_HI 2
`define HSCR_HUB_CONFIG_FIRST_REG_OC_LO 1
`define HSCR_HUB_CONFIG_FIRST_REG_PSW 0
// ==========================================
// Reset values
`define HSCR_STCMD_RST 8'h00
`define HSCR_HUB_CONFIG_FIRST_REG_RST 8'h00
`define HSCR_ID_RST 8'h00
`endif

//--- hw/hscr_pkg.sv
// Types shared by the hub configuration register bank.
package hscr_pkg;
    // ==========================================
    // Slave interface states.
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX = 3'b001,
        ST_ACK = 3'b010,
        ST_TX = 3'b011,
        ST_RACK = 3'b100,
        ST_WAIT = 3'b101
    } hscr_state_e;
    // ==========================================
    // Position within a byte transfer.
    typedef enum logic [2:0] {
        PH_WADDR = 3'b000,
        PH_REG = 3'b001,
        PH_DATA = 3'b010,
        PH_RADDR = 3'b011,
        PH_WEND = 3'b100,
        PH_RDATA = 3'b101
    } hscr_phase_e;
    // ==========================================
    // Decoded configuration byte 1 outputs.
    typedef struct packed {
        logic self_powered;
        logic led_indicator_present;
        logic full_speed_only;
        logic per_port_translator;
        logic frame_end_marker_off;
        logic [1:0] overcurrent_sense_scheme;
        logic port_switch_scheme;
    } hscr_cfg_s;
endpackage : hscr_pkg

//--- hw/hscr_regs.sv
// Hub configuration register bank behind a slave-only serial management interface.
// Behaviour
// - soft reset bit returns interface and configuration storage to reset values.
// - soft reset bit is never stored and reads zero.
// - config_lock set refuses writes to offsets 01h through 10h.
// - lock and attach bits set once, cleared only by hardware reset.
// - attach bit asserts the upstream attach request.
// - after the attaching transfer the slave interface powers down.
// - status/command and configuration byte 1 reset to zero.
// - identifiers are byte pairs, low byte at odd offset.
// - power_source_select: zero bus powered, one self powered.
// - dynamic power enable uses sense pin instead of power_source_select.
// - bit 6 reports LED indicators present.
// - bit 5 forces full speed only attachment.
// - bit 4 selects per-port transaction translators.
// - bit 3 suppresses frame end marker in full speed.
// - bits 2:1 select ganged or per-port overcurrent sensing.
// - bit 0 selects ganged or per-port power switching.
// - single byte write and read, 7-bit address, 8-bit offset and data.
// - invalid protocol leaves every register unchanged.
// - dynamic power enable comes from configuration byte 2 bit 7.
`timescale 1ns/1ps
`include "hscr_map.svh"
module hscr_regs
    import hscr_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = 7'h2c
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic srst,
    // Serial management pins, data is open drain.
    input wire logic smb_clk_i,
    input wire logic smb_data_i,
    output logic smb_data_o,
    output logic smb_data_oe,
    // Power sense pin and dynamic power enable from configuration byte 2.
    input wire logic local_supply_sense_pin,
    input wire logic dyn_power_en,
    // Configuration outputs.
    output logic [15:0] vendor_ident,
    output logic [15:0] product_ident,
    output logic [15:0] release_ident,
    output hscr_cfg_s hub_cfg,
    output logic config_lock,
    output logic usb_attach,
    output logic smb_powered_down
);
    // ==========================================
    // State of the whole block.
    typedef struct packed {
        logic scl_m, scl_s, scl_p;
        logic sda_m, sda_s, sda_p;
        logic sns_m, sns_s;
        hscr_state_e st;
        hscr_phase_e ph;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic [7:0] raddr;
        logic [7:0] wdata;
        logic sda_oe;
        logic sda_o;
        logic lock;
        logic attach;
        logic [5:0][7:0] id;
        logic [7:0] hub_config_first_reg;
        logic [15:0] vid, pid, rid;
        hscr_cfg_s cfg;
        logic off;
    } hscr_regs_s;

    hscr_regs_s q, d;
    logic scl_rise, scl_fall, start_c, stop_c, commit;
    logic [7:0] rdata;

    // Edge and bus condition detection on the synchronised pins.
    assign scl_rise = q.scl_s && !q.scl_p;
    assign scl_fall = !q.scl_s && q.scl_p;
    assign start_c = q.scl_s && q.scl_p && q.sda_p && !q.sda_s;
    assign stop_c = q.scl_s && q.scl_p && !q.sda_p && q.sda_s;
    // A write lands only on a stop right after the data acknowledge; the stop's own clock rise counts one bit.
    assign commit = stop_c && q.st == ST_RX && q.ph == PH_WEND && q.bitcnt <= 4'h1;

    // Read data selection, reserved status bits read zero.
    always_comb begin
        rdata = 8'h00;
        if (q.raddr == `HSCR_REG_STCMD) begin
            rdata[`HSCR_STC_LOCK] = q.lock;
            rdata[`HSCR_STC_ATTACH] = q.attach;
        end else if (q.raddr >= `HSCR_REG_VIDL && q.raddr <= `HSCR_REG_RIDH) begin
            rdata = q.id[q.raddr[2:0] - 3'h1];
        end else if (q.raddr == `HSCR_REG_HUB_CONFIG_FIRST_REG) begin
            rdata = q.hub_config_first_reg;
        end
    end

    // Next state: synchronisers, slave sequencer, register writes and output decode.
    always_comb begin
        d = q;
        d.scl_m = smb_clk_i;
        d.scl_s = q.scl_m;
        d.scl_p = q.scl_s;
        d.sda_m = smb_data_i;
        d.sda_s = q.sda_m;
        d.sda_p = q.sda_s;
        d.sns_m = local_supply_sense_pin;
        d.sns_s = q.sns_m;
        d.sda_o = 1'b0;
        if (q.off) begin
            d.st = ST_IDLE;
            d.sda_oe = 1'b0;
        end else if (stop_c) begin
            d.st = ST_IDLE;
            d.sda_oe = 1'b0;
        end else if (start_c) begin
            d.st = ST_RX;
            d.bitcnt = 4'h0;
            d.sda_oe = 1'b0;
            // A repeated start right after the register acknowledge turns the transfer into a read.
            d.ph = (q.ph == PH_DATA && q.st == ST_RX && q.bitcnt <= 4'h1) ? PH_RADDR : PH_WADDR;
        end else begin
            case (q.st)
                ST_IDLE: begin
                    d.sda_oe = 1'b0;
                end
                ST_RX: begin
                    if (scl_rise && q.bitcnt != 4'h8) begin
                        d.shreg = {q.shreg[6:0], q.sda_s};
                        d.bitcnt = q.bitcnt + 4'h1;
                    end else if (scl_fall && q.bitcnt == 4'h8) begin
                        d.st = ST_ACK;
                        d.sda_oe = 1'b1;
                        case (q.ph)
                            PH_WADDR: begin
                                if (q.shreg != {SLAVE_ADDR, 1'b0}) begin
                                    d.st = ST_IDLE;
                                    d.sda_oe = 1'b0;
                                end
                                d.ph = PH_REG;
                            end
                            PH_REG: begin
                                d.raddr = q.shreg;
                                d.ph = PH_DATA;
                            end
                            PH_DATA: begin
                                d.wdata = q.shreg;
                                d.ph = PH_WEND;
                            end
                            PH_RADDR: begin
                                if (q.shreg != {SLAVE_ADDR, 1'b1}) begin
                                    d.st = ST_IDLE;
                                    d.sda_oe = 1'b0;
                                end
                                d.ph = PH_RDATA;
                            end
                            default: begin
                                d.st = ST_IDLE;
                                d.sda_oe = 1'b0;
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        d.bitcnt = 4'h0;
                        if (q.ph == PH_RDATA) begin
                            d.st = ST_TX;
                            d.shreg = rdata;
                            d.sda_oe = !rdata[7];
                        end else begin
                            d.st = ST_RX;
                            d.sda_oe = 1'b0;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_rise) begin
                        d.bitcnt = q.bitcnt + 4'h1;
                    end else if (scl_fall) begin
                        if (q.bitcnt == 4'h8) begin
                            d.st = ST_RACK;
                            d.sda_oe = 1'b0;
                        end else begin
                            d.shreg = {q.shreg[6:0], 1'b0};
                            d.sda_oe = !q.shreg[6];
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        d.st = ST_WAIT;
                    end
                end
                default: begin
                    d.sda_oe = 1'b0;
                end
            endcase
        end
        // Register update on a completed write.
        if (commit) begin
            if (q.raddr == `HSCR_REG_STCMD) begin
                d.lock = q.lock | q.wdata[`HSCR_STC_LOCK];
                d.attach = q.attach | q.wdata[`HSCR_STC_ATTACH];
                if (q.wdata[`HSCR_STC_RESET]) begin
                    d.id = {6{`HSCR_ID_RST}};
                    d.hub_config_first_reg = `HSCR_HUB_CONFIG_FIRST_REG_RST;
                    d.raddr = 8'h00;
                    d.wdata = 8'h00;
                    d.ph = PH_WADDR;
                end
            end else if (!q.lock && q.raddr >= `HSCR_REG_PROT_LO && q.raddr <= `HSCR_REG_PROT_HI) begin
                if (q.raddr <= `HSCR_REG_RIDH) begin
                    d.id[q.raddr[2:0] - 3'h1] = q.wdata;
                end else if (q.raddr == `HSCR_REG_HUB_CONFIG_FIRST_REG) begin
                    d.hub_config_first_reg = q.wdata;
                end
            end
        end
        d.off = q.attach;
        d.vid = {q.id[1], q.id[0]};
        d.pid = {q.id[3], q.id[2]};
        d.rid = {q.id[5], q.id[4]};
        d.cfg.self_powered = dyn_power_en ? q.sns_s : q.hub_config_first_reg[`HSCR_HUB_CONFIG_FIRST_REG_PWR];
        d.cfg.led_indicator_present = q.hub_config_first_reg[`HSCR_HUB_CONFIG_FIRST_REG_LED];
        d.cfg.full_speed_only = q.hub_config_first_reg[`HSCR_HUB_CONFIG_FIRST_REG_FS];
        d.cfg.per_port_translator = q.hub_config_first_reg[`HSCR_HUB_CONFIG_FIRST_REG_TT];
        d.cfg.frame_end_marker_off = q.hub_config_first_reg[`HSCR_HUB_CONFIG_FIRST_REG_EOP];
        d.cfg.overcurrent_sense_scheme = q.hub_config_first_reg[`HSCR_HUB_CONFIG_FIRST_REG_OC_HI:`HSCR_HUB_CONFIG_FIRST_REG_OC_LO];
        d.cfg.port_switch_scheme = q.hub_config_first_reg[`HSCR_HUB_CONFIG_FIRST_REG_PSW];
    end

    // State register; hardware reset clears everything, including the sticky bits.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Outputs come straight from state flops.
    assign smb_data_o = q.sda_o;
    assign smb_data_oe = q.sda_oe;
    assign vendor_ident = q.vid;
    assign product_ident = q.pid;
    assign release_ident = q.rid;
    assign hub_cfg = q.cfg;
    assign config_lock = q.lock;
    assign usb_attach = q.attach;
    assign smb_powered_down = q.off;

    // ==========================================
    // Checks
    sequence s_soft;
        commit && q.raddr == `HSCR_REG_STCMD && q.wdata[`HSCR_STC_RESET];
    endsequence
    sequence s_locked_wr;
        commit && q.lock && q.raddr != `HSCR_REG_STCMD;
    endsequence
    sequence s_attach_wr;
        commit && q.raddr == `HSCR_REG_STCMD && q.wdata[`HSCR_STC_ATTACH];
    endsequence
    sequence s_lock_wr;
        commit && q.raddr == `HSCR_REG_STCMD && q.wdata[`HSCR_STC_LOCK];
    endsequence

    AST_LOCK_STICKY: assert property (@(posedge sys_clk) disable iff (srst) q.lock |=> q.lock)
        else $error("lock bit cleared without hardware reset");
    AST_ATTACH_STICKY: assert property (@(posedge sys_clk) disable iff (srst) q.attach |=> q.attach)
        else $error("attach bit cleared without hardware reset");
    AST_LOCK_BLOCKS: assert property (@(posedge sys_clk) disable iff (srst) s_locked_wr |=> ##0
        (q.id == $past(q.id) && q.hub_config_first_reg == $past(q.hub_config_first_reg)))
        else $error("write accepted while locked");
    AST_SOFT_RESET: assert property (@(posedge sys_clk) disable iff (srst) s_soft |=>
        (q.id == '0 && q.hub_config_first_reg == 8'h00 && q.st == ST_IDLE))
        else $error("soft reset did not clear storage");
    AST_POWER_DOWN: assert property (@(posedge sys_clk) disable iff (srst) $rose(q.attach) |-> ##1 q.off ##1
        (!q.sda_oe && q.st == ST_IDLE) [*3])
        else $error("interface active after attach");
    AST_NO_INVALID: assert property (@(posedge sys_clk) disable iff (srst) !commit |=>
        (q.id == $past(q.id) && q.hub_config_first_reg == $past(q.hub_config_first_reg) && q.lock == $past(q.lock)))
        else $error("register changed without a valid write");
    AST_DYN_POWER: assert property (@(posedge sys_clk) disable iff (srst) dyn_power_en |=>
        q.cfg.self_powered == $past(q.sns_s))
        else $error("dynamic power ignores sense pin");
    AST_CFG_DECODE: assert property (@(posedge sys_clk) disable iff (srst) ##1
        (q.cfg.full_speed_only == $past(q.hub_config_first_reg[5]) && q.cfg.overcurrent_sense_scheme == $past(q.hub_config_first_reg[2:1])))
        else $error("configuration decode mismatch");
    AST_RESET_ZERO: assert property (@(posedge sys_clk) srst |=> (q.hub_config_first_reg == 8'h00 && !q.lock && !q.attach))
        else $error("reset value not zero");
    AST_RESV_ZERO: assert property (@(posedge sys_clk) disable iff (srst)
        q.raddr == `HSCR_REG_STCMD |-> rdata[7:2] == 6'h00)
        else $error("reserved status bits read nonzero");
    AST_ATTACH_SET: assert property (@(posedge sys_clk) disable iff (srst) s_attach_wr |=> q.attach)
        else $error("attach request not taken");
    AST_LOCK_SET: assert property (@(posedge sys_clk) disable iff (srst) s_lock_wr |=> q.lock)
        else $error("lock request not taken");
    AST_DEAF: assert property (@(posedge sys_clk) disable iff (srst) q.off |=> (!q.sda_oe && !commit))
        else $error("interface answered while powered down");
    AST_ID_PAIR: assert property (@(posedge sys_clk) disable iff (srst) ##1
        (q.vid == $past({q.id[1], q.id[0]}) && q.rid == $past({q.id[5], q.id[4]})))
        else $error("identifier byte pairing wrong");
endmodule : hscr_regs

//--- test/hscr_host_model.sv
// Serial management host model that paces the bus clock and pulls the open-drain data line.
`timescale 1ns/1ps
module hscr_host_model #(
    parameter logic [6:0] ADDR = 7'h2c
) (
    // Pacing clock and resolved data wire.
    input wire logic sys_clk,
    input wire logic smb_wire,
    // Bus clock and data pull-down enable.
    output logic smb_clk,
    output logic data_oe
);
    // ==========================================
    // Bus idles with clock high and data released to the pull-up.
    initial begin
        smb_clk = 1'b1;
        data_oe = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : tick
    // One bit: data moves only while the clock is low, sampled late in the high phase.
    task automatic bitx(input logic v, output logic s);
        tick(1);
        data_oe = !v;
        tick(4);
        smb_clk = 1'b1;
        tick(2);
        s = smb_wire;
        tick(1);
        smb_clk = 1'b0;
    endtask : bitx
    // Start or repeated start: data falls while the clock is high.
    task automatic start();
        tick(1);
        data_oe = 1'b0;
        tick(3);
        smb_clk = 1'b1;
        tick(4);
        data_oe = 1'b1;
        tick(4);
        smb_clk = 1'b0;
    endtask : start
    // Stop: data rises while the clock is high, then the clock stands still.
    task automatic stop();
        tick(1);
        data_oe = 1'b1;
        tick(3);
        smb_clk = 1'b1;
        tick(4);
        data_oe = 1'b0;
        tick(4);
    endtask : stop
    // Byte out, most significant bit first; the ninth bit returns the acknowledge level.
    task automatic tx(input logic [7:0] b, output logic ack_n);
        logic s;
        for (int i = 7; i >= 0; i--) bitx(b[i], s);
        bitx(1'b1, ack_n);
    endtask : tx
    // Byte in, then the host's own acknowledge or not-acknowledge.
    task automatic rx(input logic nack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) bitx(1'b1, b[i]);
        bitx(nack, s);
    endtask : rx
    // Write Byte; callers keep status bits 7:3 at zero.
    task automatic wr(input logic [7:0] r, input logic [7:0] d, output logic ok);
        logic a0, a1, a2;
        start();
        tx({ADDR, 1'b0}, a0);
        tx(r, a1);
        tx(d, a2);
        stop();
        ok = !(a0 | a1 | a2);
    endtask : wr
    // Read Byte with repeated start and final not-acknowledge.
    task automatic rd(input logic [7:0] r, output logic [7:0] d);
        logic a0, a1, a2;
        start();
        tx({ADDR, 1'b0}, a0);
        tx(r, a1);
        start();
        tx({ADDR, 1'b1}, a2);
        rx(1'b1, d);
        stop();
    endtask : rd
endmodule : hscr_host_model

//--- test/hscr_regs_tb_top.sv
// Self-checking testbench of the hub configuration register bank.
`timescale 1ns/1ps
module hscr_regs_tb_top;
    import hscr_pkg::*;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic sense = 1'b0;
    logic dyn_en = 1'b0;
    logic [15:0] vid, pid, rid;
    hscr_cfg_s cfg;
    logic lock, attach, pdown, scl, host_oe, d_oe, d_o, ok;
    logic [7:0] rv;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;
    // Open-drain data wire with pull-up.
    wire smb_wire = !(host_oe | d_oe);
    hscr_regs #(.SLAVE_ADDR(7'h2c)) dut (.sys_clk(sys_clk), .srst(srst), .smb_clk_i(scl), .smb_data_i(smb_wire),
        .smb_data_o(d_o), .smb_data_oe(d_oe), .local_supply_sense_pin(sense), .dyn_power_en(dyn_en),
        .vendor_ident(vid), .product_ident(pid), .release_ident(rid), .hub_cfg(cfg), .config_lock(lock),
        .usb_attach(attach), .smb_powered_down(pdown));
    hscr_host_model #(.ADDR(7'h2c)) host (.sys_clk(sys_clk), .smb_wire(smb_wire), .smb_clk(scl), .data_oe(host_oe));
    // ==========================================
    // Clock and hang guard.
    always #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            end_of_test();
        end
    end
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic end_of_test();
        if (failures == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_of_test
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic exp_ok);
        host.wr(a, d, ok);
        check("ack", {15'h0000, ok}, {15'h0000, exp_ok});
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, rv);
        check("read", {8'h00, rv}, {8'h00, e});
    endtask : rd_chk
    // ==========================================
    // Main sequence.
    initial begin
        repeat (12) @(negedge sys_clk);
        srst = 1'b0;
        repeat (4) @(negedge sys_clk);
        for (int a = 0; a < 9; a++) rd_chk(a[7:0], 8'h00);
        check("flags", {13'h0000, lock, attach, pdown}, 16'h0000);
        check("data out", {15'h0000, d_o}, 16'h0000);
        // Identifier byte pairs, loaded by the host, checked at the identifier outputs, and offset 04h read back.
        for (int a = 1; a < 7; a++) wr(a[7:0], {4'ha, a[3:0]}, 1'b1);
        check("vendor", vid, 16'ha2a1);
        check("product", pid, 16'ha4a3);
        check("release", rid, 16'ha6a5);
        rd_chk(8'h04, 8'ha4);
        // Each configuration bit alone reaches its decoded output.
        for (int i = 0; i < 8; i++) begin
            wr(8'h07, 8'h01 << i, 1'b1);
            rd_chk(8'h07, 8'h01 << i);
            check("cfg", {8'h00, cfg}, 16'h0001 << i);
        end
        // Dynamic power takes the sense pin and ignores the stored bit.
        wr(8'h07, 8'h00, 1'b1);
        dyn_en = 1'b1;
        sense = 1'b1;
        repeat (6) @(negedge sys_clk);
        check("dyn hi", {8'h00, cfg}, 16'h0080);
        sense = 1'b0;
        wr(8'h07, 8'h80, 1'b1);
        check("dyn lo", {8'h00, cfg}, 16'h0000);
        dyn_en = 1'b0;
        @(negedge sys_clk);
        check("static", {8'h00, cfg}, 16'h0080);
        // Invalid protocols: wrong address, stop before data, extra byte.
        host.start();
        host.tx({7'h2d, 1'b0}, ok);
        host.stop();
        check("wrong addr", {15'h0000, ok}, 16'h0001);
        host.start();
        host.tx({7'h2c, 1'b0}, ok);
        host.tx(8'h07, ok);
        host.stop();
        host.start();
        host.tx({7'h2c, 1'b0}, ok);
        host.tx(8'h07, ok);
        host.tx(8'h55, ok);
        host.tx(8'h66, ok);
        host.stop();
        check("extra byte", {15'h0000, ok}, 16'h0001);
        rd_chk(8'h07, 8'h80);
        // Soft reset clears storage and never reads back as set.
        wr(8'h00, 8'h04, 1'b1);
        check("sr vid", vid, 16'h0000);
        check("sr cfg", {8'h00, cfg}, 16'h0000);
        rd_chk(8'h00, 8'h00);
        rd_chk(8'h03, 8'h00);
        // Lock refuses the protected range and survives everything but hardware reset.
        wr(8'h01, 8'h5a, 1'b1);
        wr(8'h00, 8'h02, 1'b1);
        check("lock", {15'h0000, lock}, 16'h0001);
        wr(8'h01, 8'hff, 1'b1);
        rd_chk(8'h01, 8'h5a);
        wr(8'h07, 8'h01, 1'b1);
        rd_chk(8'h07, 8'h00);
        wr(8'h00, 8'h00, 1'b1);
        rd_chk(8'h00, 8'h02);
        wr(8'h00, 8'h04, 1'b1);
        check("lock sr", {15'h0000, lock}, 16'h0001);
        check("lock sr vid", vid, 16'h0000);
        // Attach signals upstream, then the interface goes deaf.
        wr(8'h00, 8'h01, 1'b1);
        check("attach", {14'h0000, attach, pdown}, 16'h0003);
        wr(8'h00, 8'h04, 1'b0);
        check("deaf", {14'h0000, attach, lock}, 16'h0003);
        // Hardware reset alone clears lock and attach.
        srst = 1'b1;
        repeat (3) @(negedge sys_clk);
        srst = 1'b0;
        repeat (4) @(negedge sys_clk);
        check("hw reset", {13'h0000, lock, attach, pdown}, 16'h0000);
        wr(8'h01, 8'h33, 1'b1);
        rd_chk(8'h01, 8'h33);
        end_of_test();
    end
endmodule : hscr_regs_tb_top
